/* common/aes_unit_map.svh */
// register indices, field positions, reset values and timing counts of the cipher unit
//
// Summary of operation
// - each operation turns one 128-bit block into one 128-bit block by AES.
// - encrypt and decrypt in ECB, CBC, CFB, OFB and CTR with 128-bit key and IV.
// - control bits 4:2 pick the mode: 000 CBC, 001 CFB, 010 OFB, 011 CTR, 100 ECB.
// - control bit 1 picks direction: zero encrypts, one decrypts.
// - writing one to control bit 0 starts; it reads one while busy, then clears.
// - an operation takes about 45 clock cycles from the start bit.
// - completion raises the done interrupt; software reads data or polls the start bit.
// - ECB and CBC decryption run the inverse cipher from the last expanded key.
// - CBC encryption xors the previous result into the input, decryption the previous input into the output; the IV serves the first block.
// - CFB feeds the ciphertext back as next input from the IV; data xors output.
// - OFB feeds cipher output back to the core from the IV; data xors output.
// - CTR feeds an internal counter, loaded from the IV on entering the mode.
// - the counter reloads only when the mode changes away and back to CTR.
// - key, IV and data are each one byte port; a full pass is 16 accesses.
// - a full 128-bit pass starts at the 16th byte and works back to the first.
// - first index register: key pointer in 7:4, IV pointer in 3:0, advancing per access.
// - after 16 accesses each pointer wraps back to its starting value.
// - pointer n addresses row i, column j with n = 15 - i - 4j.
// - second index register holds the data pointer in 3:0; upper bits unused.
// - software may write an index register to place a pointer for partial updates.
// - control, key, IV, data and both index registers reset to zero.
`ifndef AES_UNIT_MAP_SVH
`define AES_UNIT_MAP_SVH

`define AXI_ADDR_W 12
`define IDX_CTRL 8'hE8
`define IDX_KEY 8'hF1
`define IDX_IV 8'hF2
`define IDX_DATA 8'hF3
`define IDX_PTR1 8'hF5
`define IDX_PTR2 8'hF6

`define CTRL_GO 0
`define CTRL_DECR 1
`define CTRL_MODE_LO 2
`define CTRL_MODE_HI 4
`define PTR_KEY_LO 4
`define PTR_KEY_HI 7
`define PTR_LO 0
`define PTR_HI 3

`define RST_BYTE 8'h00
`define RST_BLOCK 128'h0
`define OP_CYCLES 6'd45
`define NUM_ROUNDS 4'd10
`define RCON_FIRST 8'h01
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

/* common/aes_unit_pkg.sv */
// types and shared field arithmetic of the cipher unit
`default_nettype none
package aes_unit_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXPAND = 2'b01,
    ST_ROUND = 2'b10,
    ST_HOLD = 2'b11
  } seq_state_t;

  typedef enum logic [2:0] {
    MODE_CBC = 3'b000,
    MODE_CFB = 3'b001,
    MODE_OFB = 3'b010,
    MODE_CTR = 3'b011,
    MODE_ECB = 3'b100
  } chain_mode_t;

  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_CTRL = 3'b001,
    SEL_KEY = 3'b010,
    SEL_IV = 3'b011,
    SEL_DATA = 3'b100,
    SEL_PTR1 = 3'b101,
    SEL_PTR2 = 3'b110
  } reg_sel_t;

  function automatic logic [7:0] xtime(input logic [7:0] a);
    return {a[6:0], 1'b0} ^ (a[7] ? 8'h1b : 8'h00);
  endfunction

  function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] t;
    p = 8'h00;
    t = a;
    for (int k = 0; k < 8; k++) begin
      if (b[k]) p = p ^ t;
      t = xtime(t);
    end
    return p;
  endfunction

endpackage
`default_nettype wire

/* rtl/aes_sbox.sv */
// forward and inverse byte substitution computed from the field inverse
`timescale 1ns/1ps
`default_nettype none
module aes_sbox import aes_unit_pkg::*; (
  // byte path
  input wire logic [7:0] byte_in,
  input wire logic inv_in,
  output logic [7:0] byte_out
);

  // x^254 by square and multiply; no table to keep in sync
  function automatic logic [7:0] gf_inv(input logic [7:0] a);
    logic [7:0] r;
    r = 8'h01;
    for (int k = 7; k >= 0; k--) begin
      r = gmul(r, r);
      if (k != 0) r = gmul(r, a);
    end
    return r;
  endfunction

  function automatic logic [7:0] affine(input logic [7:0] b);
    return b ^ {b[6:0], b[7]} ^ {b[5:0], b[7:6]} ^ {b[4:0], b[7:5]} ^ {b[3:0], b[7:4]} ^ 8'h63;
  endfunction

  function automatic logic [7:0] inv_affine(input logic [7:0] s);
    return {s[6:0], s[7]} ^ {s[4:0], s[7:5]} ^ {s[1:0], s[7:2]} ^ 8'h05;
  endfunction

  always_comb begin
    if (inv_in) begin
      byte_out = gf_inv(inv_affine(byte_in));
    end else begin
      byte_out = affine(gf_inv(byte_in));
    end
  end

endmodule
`default_nettype wire

/* rtl/aes_key_step.sv */
// one round-key step of the key schedule, forward or backward
`timescale 1ns/1ps
`default_nettype none
module aes_key_step import aes_unit_pkg::*; (
  // key path
  input wire logic [127:0] key_in,
  input wire logic [7:0] rcon_in,
  input wire logic back_in,
  output logic [127:0] key_out
);

  logic [31:0] w0;
  logic [31:0] w1;
  logic [31:0] w2;
  logic [31:0] w3;
  logic [31:0] prev3;
  logic [31:0] rot_w;
  logic [31:0] sub_w;
  logic [31:0] t;

  assign w0 = key_in[127:96];
  assign w1 = key_in[95:64];
  assign w2 = key_in[63:32];
  assign w3 = key_in[31:0];
  // going backward the last word of the earlier key is recovered first
  assign prev3 = w3 ^ w2;
  assign rot_w = back_in ? {prev3[23:0], prev3[31:24]} : {w3[23:0], w3[31:24]};

  for (genvar g = 0; g < 4; g++) begin : g_sub
    aes_sbox u_sbox (
      .byte_in(rot_w[8*g +: 8]),
      .inv_in(1'b0),
      .byte_out(sub_w[8*g +: 8])
    );
  end

  assign t = sub_w ^ {rcon_in, 24'h00_0000};
  assign key_out = back_in ? {w0 ^ t, w1 ^ w0, w2 ^ w1, prev3}
                           : {w0 ^ t, w1 ^ w0 ^ t, w2 ^ w1 ^ w0 ^ t, w3 ^ w2 ^ w1 ^ w0 ^ t};

endmodule
`default_nettype wire

/* rtl/aes_cipher_unit.sv */
// block cipher unit with chaining modes and byte-port registers behind an AXI4-Lite slave
`timescale 1ns/1ps
`default_nettype none
`include "aes_unit_map.svh"
module aes_cipher_unit import aes_unit_pkg::*; (
  // clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RST_IN,
  // write address and data
  input wire logic [`AXI_ADDR_W-1:0] AWADDR_IN,
  input wire logic AWVALID_IN,
  output logic AWREADY_OUT,
  input wire logic [31:0] WDATA_IN,
  input wire logic [3:0] WSTRB_IN,
  input wire logic WVALID_IN,
  output logic WREADY_OUT,
  // write response
  output logic [1:0] BRESP_OUT,
  output logic BVALID_OUT,
  input wire logic BREADY_IN,
  // read address and data
  input wire logic [`AXI_ADDR_W-1:0] ARADDR_IN,
  input wire logic ARVALID_IN,
  output logic ARREADY_OUT,
  output logic [31:0] RDATA_OUT,
  output logic [1:0] RRESP_OUT,
  output logic RVALID_OUT,
  input wire logic RREADY_IN,
  // completion
  output logic CIPHER_DONE_INTERRUPT_OUT
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic reg_sel_t decode(input logic [`AXI_ADDR_W-1:0] a);
    reg_sel_t s;
    s = SEL_NONE;
    if (a[`AXI_ADDR_W-1:10] == '0) begin
      unique case (a[9:2])
        `IDX_CTRL: s = SEL_CTRL;
        `IDX_KEY: s = SEL_KEY;
        `IDX_IV: s = SEL_IV;
        `IDX_DATA: s = SEL_DATA;
        `IDX_PTR1: s = SEL_PTR1;
        `IDX_PTR2: s = SEL_PTR2;
        default: s = SEL_NONE;
      endcase
    end
    return s;
  endfunction

  // byte k = r + 4c sits at bits 127-8k, so pointer 15 is row 0, column 0
  function automatic logic [127:0] shift_rows(input logic [127:0] s, input logic inv);
    logic [127:0] o;
    o = s;
    for (int r = 0; r < 4; r++)
      for (int c = 0; c < 4; c++)
        o[127-8*(r+4*c) -: 8] = s[127-8*(r+4*((inv ? c+4-r : c+r)%4)) -: 8];
    return o;
  endfunction

  function automatic logic [127:0] mix_cols(input logic [127:0] s, input logic inv);
    logic [127:0] o;
    logic [7:0] a0;
    logic [7:0] a1;
    logic [7:0] a2;
    logic [7:0] a3;
    logic [7:0] m0;
    logic [7:0] m1;
    logic [7:0] m2;
    logic [7:0] m3;
    o = s;
    m0 = inv ? 8'h0e : 8'h02;
    m1 = inv ? 8'h0b : 8'h03;
    m2 = inv ? 8'h0d : 8'h01;
    m3 = inv ? 8'h09 : 8'h01;
    for (int c = 0; c < 4; c++) begin
      a0 = s[127-32*c -: 8];
      a1 = s[119-32*c -: 8];
      a2 = s[111-32*c -: 8];
      a3 = s[103-32*c -: 8];
      o[127-32*c -: 8] = gmul(a0, m0) ^ gmul(a1, m1) ^ gmul(a2, m2) ^ gmul(a3, m3);
      o[119-32*c -: 8] = gmul(a0, m3) ^ gmul(a1, m0) ^ gmul(a2, m1) ^ gmul(a3, m2);
      o[111-32*c -: 8] = gmul(a0, m2) ^ gmul(a1, m3) ^ gmul(a2, m0) ^ gmul(a3, m1);
      o[103-32*c -: 8] = gmul(a0, m1) ^ gmul(a1, m2) ^ gmul(a2, m3) ^ gmul(a3, m0);
    end
    return o;
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic aw_rdy, next_aw_rdy, aw_held, next_aw_held;
  logic [`AXI_ADDR_W-1:0] aw_addr, next_aw_addr, ar_addr, next_ar_addr;
  logic w_rdy, next_w_rdy, w_held, next_w_held, w_lane, next_w_lane;
  logic [7:0] w_data, next_w_data;
  logic b_valid, next_b_valid, r_valid, next_r_valid;
  logic [1:0] b_resp, next_b_resp, r_resp, next_r_resp;
  logic ar_rdy, next_ar_rdy, ar_held, next_ar_held;
  logic [31:0] r_data, next_r_data;
  logic go, next_go, decr, next_decr, irq, next_irq;
  logic [2:0] mode, next_mode;
  logic [127:0] key, next_key, iv, next_iv, data, next_data, ctr, next_ctr;
  logic [127:0] rk, next_rk, blk, next_blk;
  logic [3:0] kp, next_kp, ip, next_ip, dp, next_dp, rnd, next_rnd;
  logic [7:0] rcon, next_rcon;
  logic [5:0] cyc, next_cyc;
  seq_state_t seq, next_seq;

  // ---------------------------------------------------------------
  // cipher datapath
  // ---------------------------------------------------------------
  logic core_dec, last_round, do_write, do_read;
  logic [127:0] core_in, shifted, subbed, ks, mix_in, mixed, round_out;
  logic [127:0] res_data, res_iv, res_ctr;
  reg_sel_t wsel, rsel;

  always_comb begin
    core_dec = 1'b0;
    core_in = data;
    res_data = data ^ round_out;
    res_iv = iv;
    res_ctr = ctr;
    unique case (mode)
      MODE_ECB: begin
        core_dec = decr;
        res_data = round_out;
      end
      MODE_CBC: begin
        core_dec = decr;
        core_in = decr ? data : data ^ iv;
        res_data = decr ? round_out ^ iv : round_out;
        res_iv = decr ? data : round_out;
      end
      MODE_CFB: begin
        core_in = iv;
        res_iv = decr ? data : data ^ round_out;
      end
      MODE_OFB: begin
        core_in = iv;
        res_iv = round_out;
      end
      MODE_CTR: begin
        core_in = ctr;
        res_ctr = ctr + 128'h1;
      end
      default: begin
        res_data = round_out;
      end
    endcase
  end

  assign last_round = (rnd == `NUM_ROUNDS);
  assign shifted = shift_rows(blk, core_dec);

  for (genvar g = 0; g < 16; g++) begin : g_sbox
    aes_sbox u_sbox (
      .byte_in(shifted[8*g +: 8]),
      .inv_in(core_dec),
      .byte_out(subbed[8*g +: 8])
    );
  end

  // one schedule step serves expansion, encryption and the backward walk
  aes_key_step u_key_step (
    .key_in(rk),
    .rcon_in(rcon),
    .back_in(core_dec && seq == ST_ROUND),
    .key_out(ks)
  );

  assign mix_in = core_dec ? subbed ^ ks : subbed;
  assign mixed = mix_cols(mix_in, core_dec);
  assign round_out = core_dec ? (last_round ? mix_in : mixed)
                              : ((last_round ? subbed : mixed) ^ ks);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  assign wsel = decode(aw_addr);
  assign rsel = decode(ar_addr);
  assign do_write = aw_held && w_held && !b_valid;
  assign do_read = ar_held && !r_valid && !do_write;

  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_lane = w_lane;
    next_b_valid = b_valid;
    next_b_resp = b_resp;
    next_ar_held = ar_held;
    next_ar_addr = ar_addr;
    next_r_valid = r_valid;
    next_r_data = r_data;
    next_r_resp = r_resp;
    next_go = go;
    next_decr = decr;
    next_mode = mode;
    next_key = key;
    next_iv = iv;
    next_data = data;
    next_ctr = ctr;
    next_kp = kp;
    next_ip = ip;
    next_dp = dp;
    next_rk = rk;
    next_blk = blk;
    next_rnd = rnd;
    next_rcon = rcon;
    next_cyc = cyc;
    next_seq = seq;
    next_irq = 1'b0;

    if (AWVALID_IN && aw_rdy) begin
      next_aw_held = 1'b1;
      next_aw_addr = AWADDR_IN;
    end
    if (WVALID_IN && w_rdy) begin
      next_w_held = 1'b1;
      next_w_data = WDATA_IN[7:0];
      next_w_lane = WSTRB_IN[0];
    end
    if (ARVALID_IN && ar_rdy) begin
      next_ar_held = 1'b1;
      next_ar_addr = ARADDR_IN;
    end
    if (b_valid && BREADY_IN) next_b_valid = 1'b0;
    if (r_valid && RREADY_IN) next_r_valid = 1'b0;

    // byte ports write at the pointer, then advance it; 4-bit wrap realigns
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_b_valid = 1'b1;
      next_b_resp = (wsel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      if (w_lane) begin
        unique case (wsel)
          SEL_CTRL: begin
            if (!go) begin
              next_go = w_data[`CTRL_GO];
              next_decr = w_data[`CTRL_DECR];
              next_mode = w_data[`CTRL_MODE_HI:`CTRL_MODE_LO];
              next_cyc = '0;
              if (next_mode == MODE_CTR && mode != MODE_CTR) next_ctr = iv;
            end
          end
          SEL_KEY: begin
            next_key[{kp, 3'b000} +: 8] = w_data;
            next_kp = kp + 4'h1;
          end
          SEL_IV: begin
            next_iv[{ip, 3'b000} +: 8] = w_data;
            next_ip = ip + 4'h1;
          end
          SEL_DATA: begin
            next_data[{dp, 3'b000} +: 8] = w_data;
            next_dp = dp + 4'h1;
          end
          SEL_PTR1: begin
            next_kp = w_data[`PTR_KEY_HI:`PTR_KEY_LO];
            next_ip = w_data[`PTR_HI:`PTR_LO];
          end
          SEL_PTR2: begin
            next_dp = w_data[`PTR_HI:`PTR_LO];
          end
          default: begin
          end
        endcase
      end
    end

    // reads of a byte port advance its pointer as writes do
    if (do_read) begin
      next_ar_held = 1'b0;
      next_r_valid = 1'b1;
      next_r_resp = `RESP_OKAY;
      next_r_data = '0;
      unique case (rsel)
        SEL_CTRL: next_r_data[7:0] = {3'b000, mode, decr, go};
        SEL_KEY: begin
          next_r_data[7:0] = key[{kp, 3'b000} +: 8];
          next_kp = kp + 4'h1;
        end
        SEL_IV: begin
          next_r_data[7:0] = iv[{ip, 3'b000} +: 8];
          next_ip = ip + 4'h1;
        end
        SEL_DATA: begin
          next_r_data[7:0] = data[{dp, 3'b000} +: 8];
          next_dp = dp + 4'h1;
        end
        SEL_PTR1: next_r_data[7:0] = {kp, ip};
        SEL_PTR2: next_r_data[7:0] = {4'h0, dp};
        default: next_r_resp = `RESP_SLVERR;
      endcase
    end

    if (go) next_cyc = cyc + 6'd1;

    // start is taken the cycle after the control write so mode and counter are settled
    unique case (seq)
      ST_IDLE: begin
        if (go) begin
          next_rk = key;
          next_rcon = `RCON_FIRST;
          next_rnd = 4'd1;
          if (core_dec) begin
            next_seq = ST_EXPAND;
          end else begin
            next_blk = core_in ^ key;
            next_seq = ST_ROUND;
          end
        end
      end
      ST_EXPAND: begin
        next_rk = ks;
        next_rnd = rnd + 4'd1;
        if (last_round) begin
          next_blk = core_in ^ ks;
          next_rnd = 4'd1;
          next_seq = ST_ROUND;
        end else begin
          next_rcon = xtime(rcon);
        end
      end
      ST_ROUND: begin
        next_blk = round_out;
        next_rk = ks;
        next_rnd = rnd + 4'd1;
        if (core_dec) begin
          next_rcon = rcon[0] ? ({1'b0, rcon[7:1]} ^ 8'h8d) : {1'b0, rcon[7:1]};
        end else begin
          next_rcon = xtime(rcon);
        end
        if (last_round) begin
          next_data = res_data;
          next_iv = res_iv;
          next_ctr = res_ctr;
          next_seq = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // fixed length keeps the busy time the same for every mode
        if (cyc == `OP_CYCLES - 6'd1) begin
          next_go = 1'b0;
          next_irq = 1'b1;
          next_seq = ST_IDLE;
        end
      end
    endcase
  end

  assign next_aw_rdy = !next_aw_held && !next_b_valid;
  assign next_w_rdy = !next_w_held && !next_b_valid;
  assign next_ar_rdy = !next_ar_held && !next_r_valid;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      aw_rdy <= 1'b0;
      aw_held <= 1'b0;
      aw_addr <= '0;
      w_rdy <= 1'b0;
      w_held <= 1'b0;
      w_data <= `RST_BYTE;
      w_lane <= 1'b0;
      b_valid <= 1'b0;
      b_resp <= `RESP_OKAY;
      ar_rdy <= 1'b0;
      ar_held <= 1'b0;
      ar_addr <= '0;
      r_valid <= 1'b0;
      r_data <= '0;
      r_resp <= `RESP_OKAY;
      go <= 1'b0;
      decr <= 1'b0;
      mode <= 3'b000;
      key <= `RST_BLOCK;
      iv <= `RST_BLOCK;
      data <= `RST_BLOCK;
      ctr <= `RST_BLOCK;
      kp <= 4'h0;
      ip <= 4'h0;
      dp <= 4'h0;
      rk <= `RST_BLOCK;
      blk <= `RST_BLOCK;
      rnd <= 4'd1;
      rcon <= `RCON_FIRST;
      cyc <= '0;
      seq <= ST_IDLE;
      irq <= 1'b0;
    end else begin
      aw_rdy <= next_aw_rdy;
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_rdy <= next_w_rdy;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_lane <= next_w_lane;
      b_valid <= next_b_valid;
      b_resp <= next_b_resp;
      ar_rdy <= next_ar_rdy;
      ar_held <= next_ar_held;
      ar_addr <= next_ar_addr;
      r_valid <= next_r_valid;
      r_data <= next_r_data;
      r_resp <= next_r_resp;
      go <= next_go;
      decr <= next_decr;
      mode <= next_mode;
      key <= next_key;
      iv <= next_iv;
      data <= next_data;
      ctr <= next_ctr;
      kp <= next_kp;
      ip <= next_ip;
      dp <= next_dp;
      rk <= next_rk;
      blk <= next_blk;
      rnd <= next_rnd;
      rcon <= next_rcon;
      cyc <= next_cyc;
      seq <= next_seq;
      irq <= next_irq;
    end
  end

  assign AWREADY_OUT = aw_rdy;
  assign WREADY_OUT = w_rdy;
  assign BVALID_OUT = b_valid;
  assign BRESP_OUT = b_resp;
  assign ARREADY_OUT = ar_rdy;
  assign RVALID_OUT = r_valid;
  assign RDATA_OUT = r_data;
  assign RRESP_OUT = r_resp;
  assign CIPHER_DONE_INTERRUPT_OUT = irq;

endmodule
`default_nettype wire

/* tb/aes_cipher_unit_properties.sv */
// bus handshake and completion timing checker for the cipher unit
`timescale 1ns/1ps
`default_nettype none
`include "aes_unit_map.svh"
module aes_cipher_unit_checker (
  // clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RST_IN,
  // write side
  input wire logic [`AXI_ADDR_W-1:0] AWADDR_IN,
  input wire logic AWVALID_IN,
  input wire logic AWREADY_OUT,
  input wire logic [31:0] WDATA_IN,
  input wire logic [3:0] WSTRB_IN,
  input wire logic WVALID_IN,
  input wire logic WREADY_OUT,
  input wire logic [1:0] BRESP_OUT,
  input wire logic BVALID_OUT,
  input wire logic BREADY_IN,
  // read side
  input wire logic ARVALID_IN,
  input wire logic ARREADY_OUT,
  input wire logic [31:0] RDATA_OUT,
  input wire logic [1:0] RRESP_OUT,
  input wire logic RVALID_OUT,
  input wire logic RREADY_IN,
  // completion
  input wire logic CIPHER_DONE_INTERRUPT_OUT
);
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (RST_IN);
  logic wr_take;
  logic go_write;
  assign wr_take = AWVALID_IN && AWREADY_OUT && WVALID_IN && WREADY_OUT;
  assign go_write = wr_take && AWADDR_IN == {2'b00, `IDX_CTRL, 2'b00} && WSTRB_IN[0] && WDATA_IN[0];
  property p_b_hold; BVALID_OUT && !BREADY_IN |=> BVALID_OUT && $stable(BRESP_OUT); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  property p_r_hold; RVALID_OUT && !RREADY_IN |=> RVALID_OUT && $stable(RDATA_OUT); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
  property p_b_time; wr_take |=> !BVALID_OUT ##1 BVALID_OUT; endproperty
  a_b_time: assert property (p_b_time) else $error("write response late");
  property p_r_time; ARVALID_IN && ARREADY_OUT |-> ##[2:3] RVALID_OUT; endproperty
  a_r_time: assert property (p_r_time) else $error("read data late");
  property p_aw_busy; wr_take |=> !AWREADY_OUT && !WREADY_OUT; endproperty
  a_aw_busy: assert property (p_aw_busy) else $error("second write accepted");
  property p_r_byte; RVALID_OUT |-> RDATA_OUT[31:8] == 24'h0000_00; endproperty
  a_r_byte: assert property (p_r_byte) else $error("read upper bits set");
  property p_irq_pulse; CIPHER_DONE_INTERRUPT_OUT |=> !CIPHER_DONE_INTERRUPT_OUT; endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("done pulse too long");
  property p_irq_time; go_write |-> ##[45:47] CIPHER_DONE_INTERRUPT_OUT; endproperty
  a_irq_time: assert property (p_irq_time) else $error("done pulse not on time");
  property p_irq_quiet; go_write |=> !CIPHER_DONE_INTERRUPT_OUT [*8]; endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("done pulse too early");
  c_go: cover property (go_write);
  c_irq: cover property (CIPHER_DONE_INTERRUPT_OUT);
  c_err: cover property (RVALID_OUT && RRESP_OUT == 2'b10);
endmodule
bind aes_cipher_unit aes_cipher_unit_checker chk_u (.REF_CLK_IN(REF_CLK_IN), .RST_IN(RST_IN),
  .AWADDR_IN(AWADDR_IN), .AWVALID_IN(AWVALID_IN), .AWREADY_OUT(AWREADY_OUT),
  .WDATA_IN(WDATA_IN), .WSTRB_IN(WSTRB_IN), .WVALID_IN(WVALID_IN), .WREADY_OUT(WREADY_OUT),
  .BRESP_OUT(BRESP_OUT), .BVALID_OUT(BVALID_OUT), .BREADY_IN(BREADY_IN),
  .ARVALID_IN(ARVALID_IN), .ARREADY_OUT(ARREADY_OUT), .RDATA_OUT(RDATA_OUT),
  .RRESP_OUT(RRESP_OUT), .RVALID_OUT(RVALID_OUT), .RREADY_IN(RREADY_IN),
  .CIPHER_DONE_INTERRUPT_OUT(CIPHER_DONE_INTERRUPT_OUT));
`default_nettype wire

/* tb/test_aes_cipher_unit.sv */
// register-level testbench of the cipher unit
`timescale 1ns/1ps
`default_nettype none
`include "aes_unit_map.svh"
module test_block_cipher_mode_unit import aes_unit_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [`AXI_ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata;
  int fails = 0;
  int check_count = 0;
  localparam logic [127:0] KEY = 128'h0001_0203_0405_0607_0809_0a0b_0c0d_0e0f;
  localparam logic [127:0] PT = 128'h0011_2233_4455_6677_8899_aabb_ccdd_eeff;
  localparam logic [127:0] CT = 128'h69c4_e0d8_6a7b_0430_d8cd_b780_70b4_c55a;
  always #10 clk = ~clk;
  aes_cipher_unit dut_u (.REF_CLK_IN(clk), .RST_IN(rst), .AWADDR_IN(awaddr),
    .AWVALID_IN(awvalid), .AWREADY_OUT(awready), .WDATA_IN(wdata), .WSTRB_IN(wstrb),
    .WVALID_IN(wvalid), .WREADY_OUT(wready), .BRESP_OUT(bresp), .BVALID_OUT(bvalid),
    .BREADY_IN(bready), .ARADDR_IN(araddr), .ARVALID_IN(arvalid), .ARREADY_OUT(arready),
    .RDATA_OUT(rdata), .RRESP_OUT(rresp), .RVALID_OUT(rvalid), .RREADY_IN(rready),
    .CIPHER_DONE_INTERRUPT_OUT(irq));
  function automatic logic [11:0] ba(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk);
    awaddr <= ba(idx); awvalid <= 1'b1; wdata <= {24'h0000_00, d}; wstrb <= 4'h1;
    wvalid <= 1'b1;
    forever begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      // ready trails the answer by a cycle so a held response is exercised
      if (bvalid && bready) begin
        resp = bresp;
        bready <= 1'b0;
        break;
      end
      bready <= bvalid;
    end
  endtask
  task automatic rd(input logic [7:0] idx, output logic [7:0] d);
    @(posedge clk);
    araddr <= ba(idx); arvalid <= 1'b1;
    forever begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        d = rdata[7:0];
        resp = rresp;
        rready <= 1'b0;
        break;
      end
      rready <= rvalid;
    end
  endtask
  // pointer starts at 0, so the last block byte goes first
  task automatic wr_blk(input logic [7:0] idx, input logic [127:0] b);
    for (int n = 0; n < 16; n++) wr(idx, b[8*n +: 8]);
  endtask
  task automatic rd_blk(input logic [7:0] idx, output logic [127:0] b);
    for (int n = 0; n < 16; n++) rd(idx, b[8*n +: 8]);
  endtask
  task automatic op(input logic [7:0] c);
    logic [7:0] v;
    wr(`IDX_CTRL, c);
    rd(`IDX_CTRL, v);
    check(v, c);
    for (int k = 0; k < 60 && v[0]; k++) rd(`IDX_CTRL, v);
    check(v, c & 8'hfe);
  endtask
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    print_verdict();
  end
  initial begin
    logic [7:0] v;
    logic [127:0] blk;
    static chain_mode_t modes [4] = '{MODE_CBC, MODE_CFB, MODE_OFB, MODE_CTR};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    foreach (modes[i]) begin end
    for (int i = 0; i < 6; i++) begin
      // pointers first: every byte-port read advances its pointer
      rd(i == 0 ? `IDX_CTRL : i == 1 ? `IDX_PTR1 : i == 2 ? `IDX_PTR2 : i == 3 ? `IDX_KEY :
        i == 4 ? `IDX_IV : `IDX_DATA, v);
      check(v, `RST_BYTE);
    end
    rd(8'h01, v);
    check(resp, 2'b10);
    wr(8'h01, 8'h55);
    check(resp, 2'b10);
    $display("test reset and map done");
    wr(`IDX_PTR1, 8'h5a);
    rd(`IDX_PTR1, v);
    check(v, 8'h5a);
    wr_blk(`IDX_KEY, KEY);
    rd(`IDX_PTR1, v);
    check(v, 8'h5a);
    rd(`IDX_IV, v);
    rd(`IDX_PTR1, v);
    check(v, 8'h5b);
    wr(`IDX_PTR2, 8'h03);
    rd(`IDX_PTR2, v);
    check(v[3:0], 4'h3);
    wr(`IDX_PTR1, 8'h00);
    wr(`IDX_PTR2, 8'h00);
    $display("test pointers done");
    wr_blk(`IDX_KEY, KEY);
    wr_blk(`IDX_DATA, PT);
    op(8'h11);
    rd_blk(`IDX_DATA, blk);
    check(blk, CT);
    wr_blk(`IDX_DATA, CT);
    op(8'h13);
    rd_blk(`IDX_DATA, blk);
    check(blk, PT);
    $display("test ecb done");
    for (int i = 0; i < 5; i++) begin
      wr_blk(`IDX_IV, PT);
      wr_blk(`IDX_DATA, 128'h0);
      op({3'b000, modes[i > 3 ? 3 : i], 2'b01});
      rd_blk(`IDX_DATA, blk);
      check(blk == CT, i < 4);
      if (i == 0) begin
        // chain register now holds the first result, so it must cancel out here
        wr_blk(`IDX_DATA, PT ^ CT);
        op(8'h01);
        rd_blk(`IDX_DATA, blk);
        check(blk, CT);
        wr_blk(`IDX_DATA, CT);
        op(8'h03);
        rd_blk(`IDX_DATA, blk);
        check(blk, PT ^ CT);
      end
      if (i == 4) begin
        wr(`IDX_CTRL, 8'h10);
        wr_blk(`IDX_IV, PT);
        wr_blk(`IDX_DATA, 128'h0);
        op(8'h0d);
        rd_blk(`IDX_DATA, blk);
        check(blk, CT);
      end
    end
    $display("test chaining modes done");
    print_verdict();
  end
endmodule
`default_nettype wire
